// file: logic/dclk_pkg.sv
package dclk_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [15:0] OFS_LOCK_KEY   = 16'h8300;
   localparam logic [15:0] OFS_GEN_SETUP  = 16'h8304;
   localparam logic [15:0] OFS_TIMING     = 16'h8308;
   localparam logic [15:0] OFS_PIX_OUT    = 16'h830c;
   localparam logic [15:0] OFS_SS_LINE    = 16'h835c;
   // Protected registers held outside this bank
   localparam logic [15:0] OFS_FB_ST      = 16'h8310;
   localparam logic [15:0] OFS_CB_ST      = 16'h8314;
   localparam logic [15:0] OFS_CURS_ST    = 16'h8318;
   localparam logic [15:0] OFS_LINE_DELTA = 16'h8324;
   localparam logic [15:0] OFS_BUF_SIZE   = 16'h8328;
   localparam logic [15:0] OFS_TIMING_LO  = 16'h8330;
   localparam logic [15:0] OFS_TIMING_HI  = 16'h8354;

   // ****************************************
   // Key and reset values
   // ****************************************
   localparam logic [15:0] UNLOCK_KEY     = 16'h4758;
   localparam logic [31:0] RST_WORD       = 32'h0000_0000;

   // ****************************************
   // General setup field positions
   // ****************************************
   localparam int BIT_DOT_HALVE   = 31;
   localparam int BIT_PIX_HALVE   = 30;
   localparam int BIT_VID_SPEED   = 29;
   localparam int BIT_VID_ON      = 28;
   localparam int BIT_SS_ON       = 27;
   localparam int BIT_FOURTH      = 26;
   localparam int BIT_FIFO_TEST   = 25;
   localparam int BIT_LINE_REPEAT = 24;
   localparam int BIT_CLK_STROBE  = 23;
   localparam int BIT_DAC_SEL_HI  = 22;
   localparam int BIT_DAC_SEL_LO  = 20;
endpackage

// file: logic/dclk_rate_div.sv
`timescale 1ns/1ps
// ****************************************
// Dot and pixel clock enable divider
// ****************************************
module dclk_rate_div (
   input  wire logic core_clk,
   input  wire logic nrst,
   input  wire logic dot_halve,
   input  wire logic pix_halve,
   output logic      dot_en_r,
   output logic      pix_en_r
);
   logic phase_r;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         phase_r <= 1'b0;
      end else begin
         phase_r <= ~phase_r;
      end
   end

   // Dot halve wins if both are set: pixel then runs at full rate
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dot_en_r <= 1'b0;
         pix_en_r <= 1'b0;
      end else begin
         dot_en_r <= ~dot_halve | phase_r;
         pix_en_r <= dot_halve | ~pix_halve | phase_r;
      end
   end
endmodule

// file: logic/dclk_regs.sv
`timescale 1ns/1ps
module dclk_regs #(
   parameter int LINE_W = 11
) (
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              host_sel,
   input  wire logic              host_wr,
   input  wire logic [15:0]       host_addr,
   input  wire logic [31:0]       host_wdata,
   input  wire logic              line_start,
   input  wire logic [LINE_W-1:0] line_count,
   output logic [31:0]            host_rdata_r,
   output logic                   host_ack_r,
   output logic                   ext_wr_r,
   output logic [15:0]            ext_addr_r,
   output logic [31:0]            ext_wdata_r,
   output logic [31:0]            timing_setup_r,
   output logic [31:0]            pixel_output_setup_r,
   output logic                   dot_en_r,
   output logic                   pix_en_r,
   output logic                   video_port_speed_select_r,
   output logic                   motion_video_port_on_r,
   output logic                   fetch_addr_reset_r,
   output logic                   every_fourth_dword_fetch_r,
   output logic                   fifo_test_access_r,
   output logic                   fifo_ptr_reset_r,
   output logic                   repeat_line_r,
   output logic                   clock_chip_strobe_r,
   output logic [2:0]             palette_dac_reg_select_r
);
   if (LINE_W < 1 || LINE_W > 32) begin : g_bad_line_w
      $error("dclk_regs: LINE_W out of range");
   end

   // ****************************************
   // Decode helpers
   // ****************************************
   function automatic logic is_guarded(input logic [15:0] a);
      is_guarded = (a == dclk_pkg::OFS_GEN_SETUP) ||
                   (a == dclk_pkg::OFS_TIMING) ||
                   (a == dclk_pkg::OFS_PIX_OUT) ||
                   (a == dclk_pkg::OFS_FB_ST) ||
                   (a == dclk_pkg::OFS_CB_ST) ||
                   (a == dclk_pkg::OFS_CURS_ST) ||
                   (a == dclk_pkg::OFS_LINE_DELTA) ||
                   (a == dclk_pkg::OFS_BUF_SIZE) ||
                   (a >= dclk_pkg::OFS_TIMING_LO &&
                    a <= dclk_pkg::OFS_TIMING_HI);
   endfunction

   function automatic logic is_local(input logic [15:0] a);
      is_local = (a == dclk_pkg::OFS_LOCK_KEY) ||
                 (a == dclk_pkg::OFS_GEN_SETUP) ||
                 (a == dclk_pkg::OFS_TIMING) ||
                 (a == dclk_pkg::OFS_PIX_OUT) ||
                 (a == dclk_pkg::OFS_SS_LINE);
   endfunction

   logic [31:0]       lock_key_r;
   logic [31:0]       gen_r;
   logic [LINE_W-1:0] ss_line_r;
   logic              unlocked;
   logic              wr_ok;
   logic              wr_go;
   logic              fifo_test_d_r;

   // Key compared as it stands now, so a new key governs the next write
   assign unlocked = lock_key_r[15:0] == dclk_pkg::UNLOCK_KEY;
   assign wr_go    = host_sel && host_wr;
   assign wr_ok    = wr_go && (!is_guarded(host_addr) || unlocked);

   // ****************************************
   // Register writes
   // ****************************************
   // Upper key bits are stored but never consulted
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         lock_key_r <= dclk_pkg::RST_WORD;
      end else if (wr_go && host_addr == dclk_pkg::OFS_LOCK_KEY) begin
         lock_key_r <= host_wdata;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         gen_r                <= dclk_pkg::RST_WORD;
         timing_setup_r       <= dclk_pkg::RST_WORD;
         pixel_output_setup_r <= dclk_pkg::RST_WORD;
      end else if (wr_ok) begin
         case (host_addr)
            dclk_pkg::OFS_GEN_SETUP: begin
               gen_r <= host_wdata;
            end
            dclk_pkg::OFS_TIMING: begin
               timing_setup_r <= host_wdata;
            end
            dclk_pkg::OFS_PIX_OUT: begin
               pixel_output_setup_r <= host_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // Split line value is not under the lock
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ss_line_r <= '0;
      end else if (wr_go && host_addr == dclk_pkg::OFS_SS_LINE) begin
         ss_line_r <= host_wdata[LINE_W-1:0];
      end
   end

   // Guarded registers held elsewhere only see allowed writes
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ext_wr_r    <= 1'b0;
         ext_addr_r  <= 16'h0000;
         ext_wdata_r <= dclk_pkg::RST_WORD;
      end else begin
         ext_wr_r <= wr_ok && !is_local(host_addr);
         if (wr_ok && !is_local(host_addr)) begin
            ext_addr_r  <= host_addr;
            ext_wdata_r <= host_wdata;
         end
      end
   end

   // ****************************************
   // Register reads
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         host_rdata_r <= dclk_pkg::RST_WORD;
         host_ack_r   <= 1'b0;
      end else begin
         host_ack_r <= host_sel;
         if (host_sel && !host_wr) begin
            case (host_addr)
               dclk_pkg::OFS_LOCK_KEY:  host_rdata_r <= lock_key_r;
               dclk_pkg::OFS_GEN_SETUP: host_rdata_r <= gen_r;
               dclk_pkg::OFS_TIMING:    host_rdata_r <= timing_setup_r;
               dclk_pkg::OFS_PIX_OUT: begin
                  host_rdata_r <= pixel_output_setup_r;
               end
               dclk_pkg::OFS_SS_LINE: begin
                  host_rdata_r <= 32'(ss_line_r);
               end
               default: host_rdata_r <= dclk_pkg::RST_WORD;
            endcase
         end
      end
   end

   // ****************************************
   // Clock rate enables
   // ****************************************
   dclk_rate_div u_div (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .dot_halve (gen_r[dclk_pkg::BIT_DOT_HALVE]),
      .pix_halve (gen_r[dclk_pkg::BIT_PIX_HALVE]),
      .dot_en_r  (dot_en_r),
      .pix_en_r  (pix_en_r)
   );

   // ****************************************
   // Mode outputs and pins
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         video_port_speed_select_r  <= 1'b0;
         motion_video_port_on_r     <= 1'b0;
         every_fourth_dword_fetch_r <= 1'b0;
         fifo_test_access_r         <= 1'b0;
         clock_chip_strobe_r        <= 1'b0;
         palette_dac_reg_select_r   <= 3'h0;
      end else begin
         video_port_speed_select_r  <= gen_r[dclk_pkg::BIT_VID_SPEED];
         motion_video_port_on_r     <= gen_r[dclk_pkg::BIT_VID_ON];
         every_fourth_dword_fetch_r <= gen_r[dclk_pkg::BIT_FOURTH];
         fifo_test_access_r         <= gen_r[dclk_pkg::BIT_FIFO_TEST];
         clock_chip_strobe_r <= gen_r[dclk_pkg::BIT_CLK_STROBE];
         palette_dac_reg_select_r <=
            gen_r[dclk_pkg::BIT_DAC_SEL_HI:dclk_pkg::BIT_DAC_SEL_LO];
      end
   end

   // Pointer reset fires once per rise of the test bit
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fifo_test_d_r    <= 1'b0;
         fifo_ptr_reset_r <= 1'b0;
      end else begin
         fifo_test_d_r    <= gen_r[dclk_pkg::BIT_FIFO_TEST];
         fifo_ptr_reset_r <= gen_r[dclk_pkg::BIT_FIFO_TEST] &&
                             !fifo_test_d_r;
      end
   end

   // Line events are judged at the start of each line
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fetch_addr_reset_r <= 1'b0;
         repeat_line_r      <= 1'b0;
      end else begin
         fetch_addr_reset_r <= line_start &&
                               gen_r[dclk_pkg::BIT_SS_ON] &&
                               line_count == ss_line_r;
         if (line_start) begin
            repeat_line_r <= gen_r[dclk_pkg::BIT_LINE_REPEAT] &&
                             line_count[0];
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_gen_write;
      host_sel && host_wr && host_addr == dclk_pkg::OFS_GEN_SETUP;
   endsequence

   sequence s_test_rise;
      gen_r[dclk_pkg::BIT_FIFO_TEST] && !fifo_test_d_r;
   endsequence

   a_lock_blocks_gen: assert property (@(posedge core_clk) disable iff (!nrst)
      s_gen_write and !unlocked |=> $stable(gen_r))
      else $error("general setup changed while locked");

   a_unlock_takes_gen: assert property (@(posedge core_clk) disable iff (!nrst)
      s_gen_write and unlocked |=> gen_r == $past(host_wdata))
      else $error("general setup write lost while unlocked");

   a_ext_guard: assert property (@(posedge core_clk) disable iff (!nrst)
      ext_wr_r |-> $past(unlocked) || !is_guarded(ext_addr_r))
      else $error("guarded external write passed while locked");

   a_read_key: assert property (@(posedge core_clk) disable iff (!nrst)
      host_sel && !host_wr && host_addr == dclk_pkg::OFS_LOCK_KEY
      |=> host_ack_r && host_rdata_r == $past(lock_key_r))
      else $error("key read returned wrong value");

   a_test_ptr_reset: assert property (@(posedge core_clk) disable iff (!nrst)
      s_test_rise |=> fifo_ptr_reset_r ##1 !fifo_ptr_reset_r)
      else $error("pointer reset not a single pulse");

   a_split_match: assert property (@(posedge core_clk) disable iff (!nrst)
      line_start && gen_r[dclk_pkg::BIT_SS_ON] && line_count == ss_line_r
      |=> fetch_addr_reset_r)
      else $error("split screen match missed");

   a_strobe_pin: assert property (@(posedge core_clk) disable iff (!nrst)
      ##1 clock_chip_strobe_r == $past(gen_r[dclk_pkg::BIT_CLK_STROBE]))
      else $error("clock chip strobe pin differs from bit");

   a_dac_select: assert property (@(posedge core_clk) disable iff (!nrst)
      ##1 palette_dac_reg_select_r ==
      $past(gen_r[dclk_pkg::BIT_DAC_SEL_HI:dclk_pkg::BIT_DAC_SEL_LO]))
      else $error("palette select pins differ from field");

   a_dot_half_rate: assert property (@(posedge core_clk) disable iff (!nrst)
      gen_r[dclk_pkg::BIT_DOT_HALVE] [*3] |-> !(dot_en_r && $past(dot_en_r)))
      else $error("dot enable not at half rate");

   a_pix_half_rate: assert property (@(posedge core_clk) disable iff (!nrst)
      (gen_r[dclk_pkg::BIT_PIX_HALVE] && !gen_r[dclk_pkg::BIT_DOT_HALVE]) [*3]
      |-> !(pix_en_r && $past(pix_en_r)))
      else $error("pixel enable not at half rate");

   a_line_repeat: assert property (@(posedge core_clk) disable iff (!nrst)
      line_start && !gen_r[dclk_pkg::BIT_LINE_REPEAT] |=> !repeat_line_r)
      else $error("line repeated while disabled");
endmodule

// file: tb/dclk_ext_model.sv
`timescale 1ns/1ps
// ****************************************
// Palette DAC and clock synthesizer pins
// ****************************************
module dclk_ext_model (
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       strobe,
   input  wire logic [2:0] sel,
   output logic [2:0]      latched_sel,
   output logic [7:0]      strobe_count
);
   logic strobe_d;

   // Pins sampled in the core domain, so a strobe must stand a full cycle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         strobe_d     <= 1'b0;
         latched_sel  <= 3'h0;
         strobe_count <= 8'h00;
      end else begin
         strobe_d <= strobe;
         if (strobe && !strobe_d) begin
            // Only eight choices; more would need another select source
            latched_sel  <= sel;
            strobe_count <= strobe_count + 8'h01;
         end
      end
   end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
   logic        core_clk, nrst, host_sel, host_wr, line_start;
   logic [15:0] host_addr, ext_addr_r;
   logic [31:0] host_wdata, host_rdata_r, ext_wdata_r;
   logic [31:0] timing_setup_r, pixel_output_setup_r, v;
   logic [10:0] line_count;
   logic        host_ack_r, ext_wr_r, dot_en_r, pix_en_r, fetch_addr_reset_r;
   logic        video_port_speed_select_r, motion_video_port_on_r;
   logic        every_fourth_dword_fetch_r, fifo_test_access_r;
   logic        fifo_ptr_reset_r, repeat_line_r, clock_chip_strobe_r;
   logic [2:0]  palette_dac_reg_select_r, ext_sel;
   logic [7:0]  ext_cnt;
   logic        d0, p0, rd_p;
   logic [31:0] val_p;
   logic        q_rd[$];
   logic [31:0] q_val[$];
   int          n_fail, total_checks, seed;

   dclk_regs dut (.core_clk, .nrst, .host_sel, .host_wr, .host_addr,
      .host_wdata, .line_start, .line_count, .host_rdata_r, .host_ack_r,
      .ext_wr_r, .ext_addr_r, .ext_wdata_r, .timing_setup_r,
      .pixel_output_setup_r, .dot_en_r, .pix_en_r,
      .video_port_speed_select_r, .motion_video_port_on_r,
      .fetch_addr_reset_r, .every_fourth_dword_fetch_r, .fifo_test_access_r,
      .fifo_ptr_reset_r, .repeat_line_r, .clock_chip_strobe_r,
      .palette_dac_reg_select_r);

   dclk_ext_model ext (.core_clk, .nrst, .strobe(clock_chip_strobe_r),
      .sel(palette_dac_reg_select_r), .latched_sel(ext_sel),
      .strobe_count(ext_cnt));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   // Leaves the request up so back-to-back calls keep the bus busy
   task automatic acc(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
      host_sel = 1'b1;
      host_wr = w;
      host_addr = a;
      host_wdata = d;
      q_rd.push_back(!w);
      q_val.push_back(d);
      @(negedge core_clk);
   endtask

   task automatic idle(input int n);
      host_sel = 1'b0;
      repeat (n) @(negedge core_clk);
   endtask

   task automatic line(input logic [10:0] n);
      line_start = 1'b1;
      line_count = n;
      @(negedge core_clk);
      line_start = 1'b0;
   endtask

   task automatic final_report;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ****************************************
   // Read data monitor
   // ****************************************
   // Sampled mid-cycle so ack and read data are settled
   always @(negedge core_clk) begin
      if (host_ack_r === 1'b1) begin
         if (q_rd.size() == 0) begin
            n_fail++;
            $display("[FAIL] ack exp none seen 1");
         end else begin
            rd_p = q_rd.pop_front();
            val_p = q_val.pop_front();
            if (rd_p) chk("rdata", host_rdata_r, val_p);
         end
      end
   end

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   initial begin
      #20000;
      n_fail++;
      final_report();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      nrst = 1'b0;
      host_sel = 1'b0;
      host_wr = 1'b0;
      host_addr = 16'h0000;
      host_wdata = 32'h0000_0000;
      line_start = 1'b0;
      line_count = 11'h000;
      seed = 32'h1ab95269;
      repeat (5) @(negedge core_clk);
      nrst = 1'b1;
      acc(1'b1, dclk_pkg::OFS_GEN_SETUP, 32'hffff_ffff);
      acc(1'b1, dclk_pkg::OFS_TIMING, 32'h1111_1111);
      acc(1'b1, dclk_pkg::OFS_PIX_OUT, 32'h2222_2222);
      acc(1'b1, dclk_pkg::OFS_LINE_DELTA, 32'h3333_3333);
      chk("ext_wr", ext_wr_r, 32'h0);
      idle(1);
      acc(1'b0, dclk_pkg::OFS_GEN_SETUP, 32'h0);
      acc(1'b0, dclk_pkg::OFS_TIMING, 32'h0);
      acc(1'b0, dclk_pkg::OFS_PIX_OUT, 32'h0);
      acc(1'b0, 16'h8400, 32'h0);
      idle(2);
      $display("test locked done");
      // Upper key bits written as zero
      acc(1'b1, dclk_pkg::OFS_LOCK_KEY, 32'h0000_4758);
      acc(1'b1, dclk_pkg::OFS_GEN_SETUP, 32'h00d0_0000);
      acc(1'b1, dclk_pkg::OFS_LINE_DELTA, 32'h1234_5678);
      chk("ext_wr", ext_wr_r, 32'h1);
      chk("ext_addr", ext_addr_r, 32'h8324);
      chk("ext_data", ext_wdata_r, 32'h1234_5678);
      idle(1);
      acc(1'b1, dclk_pkg::OFS_GEN_SETUP, 32'h0050_0000);
      acc(1'b1, dclk_pkg::OFS_TIMING, 32'h1111_1111);
      acc(1'b0, dclk_pkg::OFS_TIMING, 32'h1111_1111);
      acc(1'b1, dclk_pkg::OFS_PIX_OUT, 32'h2222_2222);
      acc(1'b0, dclk_pkg::OFS_PIX_OUT, 32'h2222_2222);
      idle(2);
      chk("pix_out", pixel_output_setup_r, 32'h2222_2222);
      chk("ext_sel", ext_sel, 32'h5);
      chk("ext_cnt", ext_cnt, 32'h1);
      chk("timing", timing_setup_r, 32'h1111_1111);
      acc(1'b1, dclk_pkg::OFS_LOCK_KEY, 32'h0000_4759);
      acc(1'b1, dclk_pkg::OFS_GEN_SETUP, 32'hffff_ffff);
      acc(1'b0, dclk_pkg::OFS_GEN_SETUP, 32'h0050_0000);
      acc(1'b0, dclk_pkg::OFS_LOCK_KEY, 32'h0000_4759);
      idle(2);
      $display("test unlock done");
      acc(1'b1, dclk_pkg::OFS_LOCK_KEY, 32'h0000_4758);
      for (int i = 0; i < 8; i++) begin
         v = $random(seed);
         acc(1'b1, dclk_pkg::OFS_GEN_SETUP, v);
         idle(1);
         chk("modes", {video_port_speed_select_r, motion_video_port_on_r,
            every_fourth_dword_fetch_r, fifo_test_access_r,
            clock_chip_strobe_r, palette_dac_reg_select_r},
            {v[29:28], v[26:25], v[23:20]});
         acc(1'b0, dclk_pkg::OFS_GEN_SETUP, v);
         idle(1);
      end
      acc(1'b1, dclk_pkg::OFS_GEN_SETUP, 32'h0);
      idle(2);
      acc(1'b1, dclk_pkg::OFS_GEN_SETUP, 32'h0200_0000);
      idle(1);
      chk("ptr_reset", fifo_ptr_reset_r, 32'h1);
      @(negedge core_clk);
      chk("ptr_reset", fifo_ptr_reset_r, 32'h0);
      acc(1'b1, dclk_pkg::OFS_GEN_SETUP, 32'h0200_0000);
      idle(1);
      chk("ptr_reset", fifo_ptr_reset_r, 32'h0);
      $display("test modes done");
      for (int m = 0; m < 4; m++) begin
         acc(1'b1, dclk_pkg::OFS_GEN_SETUP, {m[1:0], 30'h0});
         idle(3);
         d0 = dot_en_r;
         p0 = pix_en_r;
         @(negedge core_clk);
         chk("clk_en", {d0 ^ dot_en_r, p0 ^ pix_en_r, d0 | dot_en_r,
            p0 | pix_en_r}, {m[1], m == 1, 2'b11});
      end
      $display("test clocks done");
      // Timing left as undoubled; only frame lines would be halved
      acc(1'b1, dclk_pkg::OFS_SS_LINE, 32'h0000_0123);
      acc(1'b1, dclk_pkg::OFS_GEN_SETUP, 32'h0900_0000);
      acc(1'b0, dclk_pkg::OFS_SS_LINE, 32'h0000_0123);
      idle(2);
      line(11'h123);
      chk("fetch_rst", fetch_addr_reset_r, 32'h1);
      chk("repeat", repeat_line_r, 32'h1);
      @(negedge core_clk);
      chk("fetch_rst", fetch_addr_reset_r, 32'h0);
      chk("repeat", repeat_line_r, 32'h1);
      line(11'h124);
      chk("fetch_rst", fetch_addr_reset_r, 32'h0);
      chk("repeat", repeat_line_r, 32'h0);
      @(negedge core_clk);
      acc(1'b1, dclk_pkg::OFS_GEN_SETUP, 32'h0100_0000);
      idle(2);
      line(11'h123);
      chk("fetch_rst", fetch_addr_reset_r, 32'h0);
      $display("test lines done");
      idle(3);
      chk("pending", q_rd.size(), 32'h0);
      final_report();
   end
endmodule
